// ---- hw/mtio_top.v ----
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "mtio_regs.vh"

// Function
// - Field bits 7..4 set the second register, bits 3..0 the first.
// - Top bit 0 is compare, 0x00 is pin off, bit 2 the start level.
// - Codes 0001 and 0101 drive the pin low on each compare match.
// - Codes 0010 and 0110 drive the pin high on each compare match.
// - Codes 0011 and 0111 toggle the pin on each compare match.
// - Code 1000 captures the counter on a rising pin edge.
// - Code 1001 captures the counter on a falling pin edge.
// - Codes 1010 and 1011 capture the counter on both pin edges.
// - Ch1 second field 11xx captures on the ch0 third register event.
// - Ch1 first field 11xx captures on the ch0 first register event.
// - Ch2 codes 1100, 1101 and 1110 act as 1000, 1001 and 1010.
module mtio_top
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Timer counters and channel 0 events
  input wire [15:0] cnt_ch1,
  input wire [15:0] cnt_ch2,
  input wire ch0_first_event,
  input wire ch0_third_event,
  // Pins: ch1 first, ch1 second, ch2 first, ch2 second
  input wire ch1_pin_first_sense,
  output wire ch1_pin_first_drive,
  output wire ch1_pin_first_oe,
  input wire ch1_pin_second_sense,
  output wire ch1_pin_second_drive,
  output wire ch1_pin_second_oe,
  input wire ch2_pin_first_sense,
  output wire ch2_pin_first_drive,
  output wire ch2_pin_first_oe,
  input wire ch2_pin_second_sense,
  output wire ch2_pin_second_drive,
  output wire ch2_pin_second_oe
);

  reg [7:0] io_control_ch1_q;
  reg [7:0] io_control_ch2_q;
  reg [7:0] status_q;
  reg [7:0] status_d;
  reg wr_pend_q;
  reg [7:0] addr_q;
  reg [31:0] rd_d;
  reg rd_stall_q;
  wire addr_phase;
  wire rd_req;
  wire rd_hazard;
  wire [7:0] rd_sel;
  wire [3:0] pin_in_w;
  wire [3:0] pin_out_w;
  wire [3:0] pin_oe_w;
  wire [3:0] cap_w;
  wire [3:0] match_w;
  wire [63:0] gr_w;
  wire [3:0] gr_wr_w;

  // ========================================================================
  // AHB-Lite address phase and register writes.
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_req = addr_phase & ~hwrite;
  // A read right behind a write would fetch the value from before that
  // write lands, so it costs one wait state and reads again afterwards.
  assign rd_hazard = rd_req & wr_pend_q;
  assign rd_sel = rd_stall_q ? addr_q : haddr;

  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      rd_stall_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      // Reads are normally prepared during the address phase.
      wr_pend_q <= addr_phase & hwrite;
      rd_stall_q <= rd_hazard;
      if (addr_phase)
        addr_q <= haddr;
      if ((rd_req && !rd_hazard) || rd_stall_q)
        hrdata <= rd_d;
      hreadyout <= ~rd_hazard;
      hresp <= 1'b0;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      io_control_ch1_q <= `MTIO_CTRL_RESET;
      io_control_ch2_q <= `MTIO_CTRL_RESET;
    end
    else if (wr_pend_q)
    begin
      if (addr_q == `MTIO_OFS_CTRL_CH1)
        io_control_ch1_q <= hwdata[7:0];
      if (addr_q == `MTIO_OFS_CTRL_CH2)
        io_control_ch2_q <= hwdata[7:0];
    end
  end

  // ========================================================================
  // Sticky event flags, write one to clear; a new event beats the clear.
  always @*
  begin
    status_d = status_q;
    if (wr_pend_q && addr_q == `MTIO_OFS_STATUS)
      status_d = status_q & ~hwdata[7:0];
    status_d = status_d | {match_w, cap_w};
  end

  always @(posedge clk)
  begin
    if (rst)
      status_q <= `MTIO_STAT_RESET;
    else
      status_q <= status_d;
  end

  // ========================================================================
  // Read multiplexer.
  always @*
  begin
    case (rd_sel)
      `MTIO_OFS_CTRL_CH1: rd_d = {24'h00_0000, io_control_ch1_q};
      `MTIO_OFS_CTRL_CH2: rd_d = {24'h00_0000, io_control_ch2_q};
      `MTIO_OFS_STATUS: rd_d = {24'h00_0000, status_q};
      `MTIO_OFS_GR_CH1_FIRST: rd_d = {16'h0000, gr_w[15:0]};
      `MTIO_OFS_GR_CH1_SECOND: rd_d = {16'h0000, gr_w[31:16]};
      `MTIO_OFS_GR_CH2_FIRST: rd_d = {16'h0000, gr_w[47:32]};
      `MTIO_OFS_GR_CH2_SECOND: rd_d = {16'h0000, gr_w[63:48]};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // ========================================================================
  // Pin bundling.
  assign pin_in_w = {ch2_pin_second_sense, ch2_pin_first_sense,
                     ch1_pin_second_sense, ch1_pin_first_sense};
  assign ch1_pin_first_drive = pin_out_w[0];
  assign ch1_pin_second_drive = pin_out_w[1];
  assign ch2_pin_first_drive = pin_out_w[2];
  assign ch2_pin_second_drive = pin_out_w[3];
  assign ch1_pin_first_oe = pin_oe_w[0];
  assign ch1_pin_second_oe = pin_oe_w[1];
  assign ch2_pin_first_oe = pin_oe_w[2];
  assign ch2_pin_second_oe = pin_oe_w[3];

  assign gr_wr_w[0] = wr_pend_q & (addr_q == `MTIO_OFS_GR_CH1_FIRST);
  assign gr_wr_w[1] = wr_pend_q & (addr_q == `MTIO_OFS_GR_CH1_SECOND);
  assign gr_wr_w[2] = wr_pend_q & (addr_q == `MTIO_OFS_GR_CH2_FIRST);
  assign gr_wr_w[3] = wr_pend_q & (addr_q == `MTIO_OFS_GR_CH2_SECOND);

  // ========================================================================
  // Units: index bit 0 picks first or second register, bit 1 the channel.
  genvar i;
  generate
    for (i = 0; i < `MTIO_UNITS; i = i + 1)
    begin : g_unit
      wire [7:0] ctrl_w;
      wire [3:0] func_w;
      wire [15:0] cnt_w;
      wire ch0_w;
      assign ctrl_w = (i < 2) ? io_control_ch1_q : io_control_ch2_q;
      assign func_w = (i % 2 == 0) ?
        ctrl_w[`MTIO_FIRST_FIELD_LSB +: `MTIO_FIELD_W] :
        ctrl_w[`MTIO_SECOND_FIELD_LSB +: `MTIO_FIELD_W];
      assign cnt_w = (i < 2) ? cnt_ch1 : cnt_ch2;
      assign ch0_w = (i % 2 == 0) ? ch0_first_event : ch0_third_event;
      mtio_gr_unit #(
        .IS_CH1((i < 2) ? 1 : 0)
      ) u_unit (
        .clk(clk),
        .rst(rst),
        .func(func_w),
        .cnt(cnt_w),
        .ch0_evt(ch0_w),
        .wr_en(gr_wr_w[i]),
        .wr_data(hwdata[15:0]),
        .pin_sense(pin_in_w[i]),
        .pin_drive(pin_out_w[i]),
        .pin_oe(pin_oe_w[i]),
        .gr_q(gr_w[16*i +: 16]),
        .cap_evt(cap_w[i]),
        .match_evt(match_w[i])
      );
    end
  endgenerate

endmodule

// ---- hw/mtio_regs.vh ----
`ifndef MTIO_REGS_VH
`define MTIO_REGS_VH

// ==========================================================================
// Register byte offsets.
`define MTIO_OFS_CTRL_CH1 8'h00
`define MTIO_OFS_CTRL_CH2 8'h04
`define MTIO_OFS_STATUS 8'h08
`define MTIO_OFS_GR_CH1_FIRST 8'h10
`define MTIO_OFS_GR_CH1_SECOND 8'h14
`define MTIO_OFS_GR_CH2_FIRST 8'h18
`define MTIO_OFS_GR_CH2_SECOND 8'h1C

// ==========================================================================
// Field positions inside a control register.
`define MTIO_FIRST_FIELD_LSB 0
`define MTIO_SECOND_FIELD_LSB 4
`define MTIO_FIELD_W 4
`define MTIO_FLD_CAPTURE 3
`define MTIO_FLD_INIT_LEVEL 2
`define MTIO_FLD_SRC_CH0 2

// Status layout: capture flags low, compare-match flags high.
`define MTIO_STAT_CAP_LSB 0
`define MTIO_STAT_MATCH_LSB 4

// ==========================================================================
// Reset values and widths.
`define MTIO_CTRL_RESET 8'h00
`define MTIO_GR_RESET 16'h0000
`define MTIO_STAT_RESET 8'h00
`define MTIO_GR_W 16
`define MTIO_UNITS 4

// Capture edge select in field bits 1..0.
`define MTIO_EDGE_RISE 2'b00
`define MTIO_EDGE_FALL 2'b01

`endif

// ---- hw/mtio_gr_unit.v ----
`timescale 1ns/1ps
`include "mtio_regs.vh"

// One general register with its pin: output compare or input capture.
module mtio_gr_unit #(
  parameter IS_CH1 = 1
)
(
  // Clock and reset
  input wire clk,
  input wire rst,
  // Configuration and counter
  input wire [3:0] func,
  input wire [15:0] cnt,
  input wire ch0_evt,
  // Software write
  input wire wr_en,
  input wire [15:0] wr_data,
  // Pin
  input wire pin_sense,
  output reg pin_drive,
  output reg pin_oe,
  // Results
  output reg [15:0] gr_q,
  output reg cap_evt,
  output reg match_evt
);

  reg pin_prev_q;
  reg match_prev_q;
  reg [3:0] func_prev_q;
  wire is_capture;
  wire rise;
  wire fall;
  wire match_now;
  wire match_edge;
  reg edge_hit;

  assign is_capture = func[`MTIO_FLD_CAPTURE];
  assign rise = pin_sense & ~pin_prev_q;
  assign fall = ~pin_sense & pin_prev_q;
  assign match_now = (cnt == gr_q);
  // A counter resting on the match value must not fire again every clock.
  assign match_edge = match_now & ~match_prev_q;

  // ========================================================================
  // Capture trigger selection.
  always @*
  begin
    if (IS_CH1 != 0 && func[`MTIO_FLD_SRC_CH0])
      edge_hit = ch0_evt;
    else
      case (func[1:0])
        `MTIO_EDGE_RISE: edge_hit = rise;
        `MTIO_EDGE_FALL: edge_hit = fall;
        default: edge_hit = rise | fall;
      endcase
  end

  // ========================================================================
  // Register, pin and event flops.
  always @(posedge clk)
  begin
    if (rst)
    begin
      gr_q <= `MTIO_GR_RESET;
      pin_prev_q <= 1'b0;
      match_prev_q <= 1'b0;
      func_prev_q <= 4'h0;
      pin_drive <= 1'b0;
      pin_oe <= 1'b0;
      cap_evt <= 1'b0;
      match_evt <= 1'b0;
    end
    else
    begin
      pin_prev_q <= pin_sense;
      match_prev_q <= match_now & ~is_capture;
      func_prev_q <= func;
      cap_evt <= is_capture & edge_hit;
      match_evt <= ~is_capture & match_edge;
      // A capture in the same cycle as a software write wins.
      if (is_capture && edge_hit)
        gr_q <= cnt;
      else if (wr_en)
        gr_q <= wr_data;
      pin_oe <= ~is_capture & (func[1:0] != 2'b00);
      if (!is_capture)
      begin
        if (func != func_prev_q)
          pin_drive <= func[`MTIO_FLD_INIT_LEVEL];
        else if (match_edge)
          case (func[1:0])
            2'b01: pin_drive <= 1'b0;
            2'b10: pin_drive <= 1'b1;
            2'b11: pin_drive <= ~pin_drive;
            default: pin_drive <= pin_drive;
          endcase
      end
    end
  end

endmodule

// ---- test/mtio_top_props.sv ----
`timescale 1ns/1ps
// ==========
// Mirrors the channel 1 first field and register from bus writes; a
// capture is not seen, so match checks hold only in compare mode.
module mtio_props
(
  // Clock, reset and bus
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // Channel 1 first unit
  input wire [15:0] cnt_ch1,
  input wire ch1_pin_first_drive,
  input wire ch1_pin_first_oe
);
  reg w_q;
  reg m_q;
  reg [7:0] a_q;
  reg [3:0] f_q;
  reg [3:0] fc_q;
  reg [15:0] g_q;
  wire m = cnt_ch1 == g_q;
  wire cmp = !f_q[3];
  wire chg = f_q != fc_q;
  wire hit = cmp && !chg && m && !m_q;
  wire [1:0] act = f_q[1:0];
  wire o = ch1_pin_first_drive;
  wire e = ch1_pin_first_oe;
  always @(posedge clk)
  begin
    w_q <= hsel && htrans[1] && hready && hwrite && !rst;
    a_q <= haddr;
    // The unit forgets a match across reset and while it captures.
    m_q <= m && cmp && !rst;
    fc_q <= f_q;
    if (rst)
    begin
      f_q <= 4'h0;
      g_q <= 16'h0000;
    end
    else if (w_q && a_q == 8'h00)
      f_q <= hwdata[3:0];
    else if (w_q && a_q == 8'h10)
      g_q <= hwdata[15:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_off: assert property ((cmp && act == 0) [*2] |-> !e)
    else $error("pin driven while off");
  a_oe_on: assert property ((cmp && act != 0) [*2] |-> e)
    else $error("pin not driven");
  a_oe_capture: assert property (f_q[3] [*2] |-> !e)
    else $error("pin driven in capture");
  a_init_level: assert property (cmp && act == 0 && chg |=> o == f_q[2])
    else $error("initial level wrong");
  a_pin_holds: assert property (cmp && !chg && !(m && !m_q) |=> $stable(o))
    else $error("pin moved without cause");
  a_match_low: assert property (hit && act == 1 |=> !o)
    else $error("match did not drive low");
  a_match_high: assert property (hit && act == 2 |=> o)
    else $error("match did not drive high");
  a_match_toggle: assert property (hit && act == 3 |=> o != $past(o))
    else $error("match did not toggle");
  c_toggle: cover property (hit && act == 3);
  c_capture: cover property (f_q[3] && !e);
  c_init_one: cover property (chg && f_q == 4'h4);
endmodule
bind mtio_top mtio_props u_props (.clk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .cnt_ch1, .ch1_pin_first_drive,
  .ch1_pin_first_oe);

// ---- test/mtio_top_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
// ==========
// Bench: bus master, pin and event driver, read-data scoreboard.
module mtio_top_bench;
  reg clk = 0, rst = 1, hsel = 0, hwrite = 0, e0a = 0, e0c = 0, rdp = 0;
  reg [7:0] haddr = 8'h00, ga;
  reg [1:0] htrans = 2'h0;
  reg [31:0] hwdata = 32'h0000_0000, ex;
  reg [15:0] c1 = 16'h0000, c2 = 16'h0000, lf = 16'h0062, r1, r2;
  reg [3:0] pin = 4'h0;
  reg xp;
  wire [31:0] hrdata;
  wire [3:0] po, oe;
  wire hrdy, hresp;
  int n_mismatch = 0, n_tests = 0;
  reg [31:0] expq[$];
  always #4 clk = ~clk;
  mtio_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
    .cnt_ch1(c1), .cnt_ch2(c2), .ch0_first_event(e0a),
    .ch0_third_event(e0c), .ch1_pin_first_sense(pin[0]),
    .ch1_pin_first_drive(po[0]), .ch1_pin_first_oe(oe[0]),
    .ch1_pin_second_sense(pin[1]), .ch1_pin_second_drive(po[1]),
    .ch1_pin_second_oe(oe[1]), .ch2_pin_first_sense(pin[2]),
    .ch2_pin_first_drive(po[2]), .ch2_pin_first_oe(oe[2]),
    .ch2_pin_second_sense(pin[3]), .ch2_pin_second_drive(po[3]),
    .ch2_pin_second_oe(oe[3]));
  function automatic [15:0] nxt(input [15:0] x);
    nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // A slave that never answers must not hang the run.
  task automatic hold();
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (hrdy === 1'b1)
        return;
    end
    n_mismatch++;
    summarize();
  endtask
  task automatic bus(input [7:0] a, input w, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold();
  endtask
  task automatic rd(input [7:0] a, input [31:0] e);
    expq.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  // Write then read the same word back to back, so the read address
  // phase overlaps the write data phase.
  task automatic wr_rd(input [7:0] a, input [31:0] d);
    expq.push_back(d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b1;
    hold();
    hwrite <= 1'b0;
    hwdata <= d;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hold();
  endtask
  always @(posedge clk)
  begin
    if (rdp && hrdy === 1'b1)
    begin
      ex = expq.pop_front();
      `CHK("read data", ex, hrdata)
      `CHK("response", 1'b0, hresp)
    end
    // A wait state keeps the pending read open until ready returns.
    if (hrdy === 1'b1)
      rdp <= hsel && htrans[1] && !hwrite && !rst;
  end
  initial
  begin
    wt(10);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("pins", {po, oe}, 8'h00)
    // Counters and registers all reset to zero, so every unit sits in
    // compare mode on a match and raises its match flag.
    for (int a = 0; a < 36; a += 4)
      rd(8'(a), a == 8 ? 32'h0000_00f0 : 32'h0000_0000);
    $display("reset values done");
    for (int k = 0; k < 8; k++)
    begin
      lf = nxt(lf);
      c1 <= lf + 16'h0001;
      bus(8'h10, 1'b1, {16'h0000, lf});
      bus(8'h00, 1'b1, 32'(k));
      wt(2);
      `CHK("init", po[0], k[2])
      `CHK("enable", oe[0], k[1:0] != 0)
      c1 <= lf;
      wt(3);
      xp = k[1:0] == 1 ? 1'b0 : k[1:0] == 2 ? 1'b1 : k[2] ^ (k[1:0] == 3);
      `CHK("match", po[0], xp)
    end
    $display("compare codes done");
    for (int u = 0; u < 2; u++)
      for (int k = 8; k < 16; k++)
      begin
        lf = nxt(lf);
        r1 = lf;
        r2 = ~lf;
        ga = 8'h18 + 8'(u * 4);
        bus(8'h04, 1'b1, 32'(k << (4 * u)));
        bus(ga, 1'b1, 32'h0000_0000);
        c2 <= r1;
        pin[2 + u] <= 1'b1;
        wt(3);
        rd(ga, {16'h0000, k[1:0] == 2'h1 ? 16'h0000 : r1});
        c2 <= r2;
        pin[2 + u] <= 1'b0;
        wt(3);
        rd(ga, 32'(k[1:0] == 2'h0 ? r1 : r2));
      end
    $display("pin capture done");
    bus(8'h00, 1'b1, 32'h0000_00cc);
    c1 <= r1;
    e0a <= 1'b1;
    @(posedge clk);
    e0a <= 1'b0;
    wt(2);
    rd(8'h10, {16'h0000, r1});
    rd(8'h14, 32'h0000_0000);
    c1 <= r2;
    e0c <= 1'b1;
    @(posedge clk);
    e0c <= 1'b0;
    wt(2);
    rd(8'h14, {16'h0000, r2});
    rd(8'h10, {16'h0000, r1});
    wt(2);
    $display("event capture done");
    lf = nxt(lf);
    wr_rd(8'h1c, {16'h0000, lf});
    wt(2);
    $display("back to back done");
    summarize();
  end
endmodule
